// ===== include/clpp_pkg.sv
// Purpose: Shared constants and types for the cascaded legacy interrupt controller pair
// Assumes: One 10 MHz clock, synchronous active-high reset
// Notes:   Core 0 is the master, core 1 the slave
package clpp_pkg;

    localparam int CORE_W      = 8;
    localparam int NUM_CORES   = 2;
    localparam int NUM_LEVELS  = 16;
    localparam int MASTER      = 0;
    localparam int SLAVE       = 1;
    localparam int VEC_BASE_LSB = 3;

    // Level numbers of the specially wired inputs
    localparam int LVL_TIMER   = 0;
    localparam int LVL_KBD     = 1;
    localparam int LVL_CASCADE = 2;
    localparam int LVL_RTC     = 8;
    localparam int LVL_MOUSE   = 12;
    localparam int LVL_FPU     = 13;
    localparam int LVL_IDE_PRI = 14;
    localparam int LVL_IDE_SEC = 15;

    localparam logic [2:0]  CASCADE_INPUT   = 3'h2;
    localparam logic [2:0]  SLAVE_ID        = 3'h2;
    localparam logic [2:0]  SPURIOUS_LEVEL  = 3'h7;
    // Levels 0, 2, 8 and 13 have no edge/level choice
    localparam logic [15:0] FIXED_MODE_LEVELS = 16'h2105;
    // Cascade input follows the slave output as a level
    localparam logic [15:0] FORCED_LEVEL      = 16'h0004;

    localparam logic [7:0]  IRR_RESET  = 8'h00;
    localparam logic [7:0]  ISR_RESET  = 8'h00;
    localparam logic [7:0]  MASK_RESET = 8'hff;
    localparam logic [4:0]  BASE_RESET = 5'h00;

    typedef enum logic [2:0] {
        CLPP_IDLE,
        CLPP_ACK1,
        CLPP_GAP,
        CLPP_ACK2,
        CLPP_DONE
    } clpp_state_t;

    typedef struct packed {
        logic [7:0] pending_request_bits;
        logic [7:0] in_service_bits;
        logic [7:0] request_mask_bits;
    } clpp_core_stat_t;

    typedef struct packed {
        logic [1:0] mask_we;
        logic [1:0] base_we;
        logic [1:0] end_of_service_command;
        logic [7:0] data;
    } clpp_sw_cmd_t;

endpackage

// ===== src/clpp_top.sv
// Purpose: Two cascaded 8-input interrupt controller cores with acknowledge sequencer
// Assumes: All inputs synchronous to sys_clk; serialized link already decoded per level
// Notes:   Init/operation word decoding, rotation, poll and special nested modes live elsewhere
//
// Overview of operation
// - Master and slave cores, eight inputs each
// - Slave output drives master input two
// - Timer, clock and FPU sources wired internally
// - Levels 14/15 from drive pins in legacy
// - Per-level edge/level, except 0,2,8,13
// - Optional latches on levels 12 and 1
// - Request set by edge or level, unmasked
// - Masked levels never raise processor request
// - First pulse moves winner into service
// - Acknowledge cycle makes two internal pulses
// - First pulse freezes requests for resolution
// - Master broadcasts cascade code after pulse one
// - Vector is base plus level code
// - Vanished request returns master level seven
// - Auto mode clears service bit after pulse two
// - Separate vector base per core
// - Code 010 hands vector to slave
// - Fixed priority, in-service blocks lower levels
`timescale 1ns/1ps
module clpp_top
    import clpp_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    input  wire clpp_sw_cmd_t            sw_cmd,
    input  wire logic                    auto_end_of_service_mode,
    input  wire logic [NUM_LEVELS-1:0]   edge_level_sel,
    input  wire logic                    latch_irq12_en,
    input  wire logic                    latch_irq1_en,
    input  wire logic                    kbd_latch_clear,
    input  wire logic                    timer0_out,
    input  wire logic                    multimedia_timer0,
    input  wire logic                    rtc_irq,
    input  wire logic                    multimedia_timer1,
    input  wire logic                    fpu_error_n,
    input  wire logic [NUM_LEVELS-1:0]   serialized_irq_link,
    input  wire logic                    ide_pri_irq,
    input  wire logic                    ide_sec_irq,
    input  wire logic                    ide_pri_legacy,
    input  wire logic                    ide_sec_legacy,
    input  wire logic                    pci_internal_ack_pulse_n_req,
    output logic                         cpu_irq_out,
    output logic                         internal_ack_pulse_n,
    output logic [2:0]                   cascade_code,
    output logic                         pci_internal_ack_pulse_n_done,
    output logic [7:0]                   pci_internal_ack_pulse_n_vector,
    output clpp_core_stat_t [NUM_CORES-1:0] core_status
);

    // Lowest set bit wins: {found, index}
    function automatic logic [3:0] pick(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = CORE_W - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] onehot(input logic [3:0] p);
        logic [7:0] r;
        r = 8'h00;
        if (p[3]) begin
            r[p[2:0]] = 1'b1;
        end
        return r;
    endfunction

    // Bits strictly above in priority than the highest in-service level
    function automatic logic [7:0] above(input logic [7:0] isr_v);
        logic [3:0] p;
        p = pick(isr_v);
        return p[3] ? ((8'h01 << p[2:0]) - 8'h01) : 8'hff;
    endfunction

    clpp_state_t          state;
    clpp_state_t          next_state;
    logic [7:0]           pending_request_bits   [NUM_CORES];
    logic [7:0]           in_service_bits   [NUM_CORES];
    logic [7:0]           request_mask_bits   [NUM_CORES];
    logic [4:0]           base  [NUM_CORES];
    logic [NUM_LEVELS-1:0] prev_req;
    logic                 kbd_latch;
    logic                 mouse_latch;
    logic                 fpu_irq;
    logic                 took_m;
    logic                 took_s;
    logic [2:0]           m_idx;
    logic [2:0]           s_idx;
    logic [7:0]           vec_hold;

    logic [NUM_LEVELS-1:0] raw_in;
    logic [NUM_LEVELS-1:0] req_in;
    logic [NUM_LEVELS-1:0] level_mode;
    logic [NUM_LEVELS-1:0] set_req;
    logic [NUM_LEVELS-1:0] drop_req;
    logic [7:0]           elig  [NUM_CORES];
    logic [7:0]           take  [NUM_CORES];
    logic [7:0]           clr_svc [NUM_CORES];
    logic [3:0]           m_pick;
    logic [3:0]           s_pick;
    logic                 frozen;
    logic                 slave_int;
    logic                 slave_resp;
    logic [7:0]           resp_vec;

    // drive pins only in legacy mode
    assign raw_in = {
        ide_sec_legacy ? ide_sec_irq : serialized_irq_link[LVL_IDE_SEC],
        ide_pri_legacy ? ide_pri_irq : serialized_irq_link[LVL_IDE_PRI],
        fpu_irq,
        latch_irq12_en ? mouse_latch : serialized_irq_link[LVL_MOUSE],
        serialized_irq_link[11:9],
        rtc_irq | multimedia_timer1,
        serialized_irq_link[7:3],
        1'b0,
        latch_irq1_en ? kbd_latch : serialized_irq_link[LVL_KBD],
        timer0_out | multimedia_timer0
    };

    // slave output on master input two
    assign slave_int = |elig[SLAVE];
    assign req_in    = raw_in | (FORCED_LEVEL & {NUM_LEVELS{slave_int}});

    // per-level trigger choice with fixed exceptions
    assign level_mode = (edge_level_sel & ~FIXED_MODE_LEVELS) | FORCED_LEVEL;

    // edge or level sets request, mask ignored
    assign set_req  = (level_mode & req_in) | (~level_mode & req_in & ~prev_req);
    assign drop_req = level_mode & ~req_in;

    // requests held still during the sequence
    assign frozen = (state != CLPP_IDLE);

    assign elig[MASTER] = pending_request_bits[MASTER] & ~request_mask_bits[MASTER] & above(in_service_bits[MASTER]);
    assign elig[SLAVE]  = pending_request_bits[SLAVE]  & ~request_mask_bits[SLAVE]  & above(in_service_bits[SLAVE]);
    assign m_pick = pick(elig[MASTER]);
    assign s_pick = pick(elig[SLAVE]);

    // winner moves into service on first pulse
    assign take[MASTER] = (state == CLPP_ACK1) ? onehot(m_pick) : 8'h00;
    assign take[SLAVE]  = (state == CLPP_ACK1 && m_pick == {1'b1, CASCADE_INPUT})
                          ? onehot(s_pick) : 8'h00;

    // slave answers when its code is broadcast
    assign slave_resp = took_m && (cascade_code == SLAVE_ID) && took_s;

    // nothing left pending gives master level seven
    // each core uses its own base
    assign resp_vec = !took_m   ? {base[MASTER], SPURIOUS_LEVEL} :
                      slave_resp ? {base[SLAVE], s_idx} : {base[MASTER], m_idx};

    always_comb begin
        next_state = state;
        case (state)
            CLPP_IDLE: begin
                if (pci_internal_ack_pulse_n_req) begin
                    next_state = CLPP_ACK1;
                end
            end
            CLPP_ACK1: next_state = CLPP_GAP;
            CLPP_GAP:  next_state = CLPP_ACK2;
            CLPP_ACK2: next_state = CLPP_DONE;
            CLPP_DONE: next_state = CLPP_IDLE;
            default:   next_state = CLPP_IDLE;
        endcase
    end

    genvar c;
    generate
        for (c = 0; c < NUM_CORES; c++) begin : g_core
            // auto clear after pulse two, else command
            assign clr_svc[c] =
                (sw_cmd.end_of_service_command[c] ? onehot(pick(in_service_bits[c])) : 8'h00) |
                ((state == CLPP_DONE && auto_end_of_service_mode)
                    ? onehot(c == MASTER ? {took_m, m_idx} : {took_s, s_idx}) : 8'h00);

            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    pending_request_bits[c]  <= IRR_RESET;
                    in_service_bits[c]  <= ISR_RESET;
                    request_mask_bits[c]  <= MASK_RESET;
                    base[c] <= BASE_RESET;
                end else begin
                    pending_request_bits[c] <= frozen ? (pending_request_bits[c] & ~take[c])
                            : ((pending_request_bits[c] & ~drop_req[c*CORE_W +: CORE_W])
                               | set_req[c*CORE_W +: CORE_W]);
                    in_service_bits[c] <= (in_service_bits[c] & ~clr_svc[c]) | take[c];
                    if (sw_cmd.mask_we[c]) begin
                        request_mask_bits[c] <= sw_cmd.data;
                    end
                    if (sw_cmd.base_we[c]) begin
                        base[c] <= sw_cmd.data[7:VEC_BASE_LSB];
                    end
                end
            end

            assign core_status[c] = '{pending_request_bits: pending_request_bits[c], in_service_bits: in_service_bits[c], request_mask_bits: request_mask_bits[c]};
        end
    endgenerate

    // Edge history only advances while not frozen, so an edge during a sequence lands after it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prev_req <= 16'h0000;
        end else if (!frozen) begin
            prev_req <= req_in;
        end
    end

    // Set wins over clear on the keyboard and mouse latches
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            kbd_latch   <= 1'b0;
            mouse_latch <= 1'b0;
            fpu_irq     <= 1'b0;
        end else begin
            kbd_latch   <= (kbd_latch & ~kbd_latch_clear) | serialized_irq_link[LVL_KBD];
            mouse_latch <= (mouse_latch & ~kbd_latch_clear) | serialized_irq_link[LVL_MOUSE];
            fpu_irq     <= ~fpu_error_n;
        end
    end

    // two internal pulses per acknowledge cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state                <= CLPP_IDLE;
            internal_ack_pulse_n <= 1'b1;
        end else begin
            state                <= next_state;
            internal_ack_pulse_n <= !(next_state == CLPP_ACK1 || next_state == CLPP_ACK2);
        end
    end

    // code broadcast at the trailing edge of pulse one
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cascade_code <= 3'h0;
            took_m       <= 1'b0;
            took_s       <= 1'b0;
            m_idx        <= 3'h0;
            s_idx        <= 3'h0;
        end else if (state == CLPP_ACK1) begin
            cascade_code <= m_pick[2:0];
            took_m       <= m_pick[3];
            took_s       <= |take[SLAVE];
            m_idx        <= m_pick[2:0];
            s_idx        <= s_pick[2:0];
        end
    end

    // vector and completion after pulse two
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            vec_hold        <= 8'h00;
            pci_internal_ack_pulse_n_vector <= 8'h00;
            pci_internal_ack_pulse_n_done   <= 1'b0;
        end else begin
            if (state == CLPP_ACK2) begin
                vec_hold <= resp_vec;
            end
            pci_internal_ack_pulse_n_done <= (state == CLPP_DONE);
            if (state == CLPP_DONE) begin
                pci_internal_ack_pulse_n_vector <= vec_hold;
            end
        end
    end

    // processor request from unmasked pending only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cpu_irq_out <= 1'b0;
        end else begin
            cpu_irq_out <= |elig[MASTER];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    mask_block_a: assert property (
        cpu_irq_out |-> |$past(pending_request_bits[MASTER] & ~request_mask_bits[MASTER]))
        else $error("Request output raised with nothing unmasked");
    irq_raise_a: assert property (
        (|elig[MASTER]) |=> cpu_irq_out)
        else $error("Unmasked pending request did not raise output");
    ack_pulses_a: assert property (
        (state == CLPP_IDLE && pci_internal_ack_pulse_n_req) |=>
            !internal_ack_pulse_n ##1 internal_ack_pulse_n ##1
            !internal_ack_pulse_n ##1 internal_ack_pulse_n)
        else $error("Acknowledge pulse pair malformed");
    done_latency_a: assert property (
        (state == CLPP_IDLE && pci_internal_ack_pulse_n_req) |-> ##5 pci_internal_ack_pulse_n_done)
        else $error("Acknowledge cycle not completed in five cycles");
    take_service_a: assert property (
        (state == CLPP_ACK1 && m_pick[3]) |=>
            ((in_service_bits[MASTER] & $past(onehot(m_pick))) != 8'h00) &&
            ((pending_request_bits[MASTER] & $past(onehot(m_pick))) == 8'h00))
        else $error("Winner not moved from pending to service");
    freeze_irr_a: assert property (
        (frozen && $past(frozen)) |->
            ((pending_request_bits[MASTER] & ~$past(pending_request_bits[MASTER])) == 8'h00) &&
            ((pending_request_bits[SLAVE] & ~$past(pending_request_bits[SLAVE])) == 8'h00))
        else $error("Pending bits rose while frozen");
    cascade_code_a: assert property (
        (state == CLPP_GAP) |-> cascade_code == $past(m_pick[2:0]))
        else $error("Cascade code not the master winner");
    spurious_vec_a: assert property (
        (state == CLPP_ACK1 && !m_pick[3]) |-> ##4
            pci_internal_ack_pulse_n_done && pci_internal_ack_pulse_n_vector[2:0] == SPURIOUS_LEVEL)
        else $error("Vanished request gave wrong vector");
    vector_code_a: assert property (
        (pci_internal_ack_pulse_n_done && took_m && !slave_resp) |->
            pci_internal_ack_pulse_n_vector == {base[MASTER], m_idx})
        else $error("Master vector bits wrong");
    auto_clear_a: assert property (
        (state == CLPP_DONE && auto_end_of_service_mode && took_m) |=>
            !in_service_bits[MASTER][m_idx])
        else $error("Auto mode left service bit set");

    cov_master_ack: cover property (pci_internal_ack_pulse_n_done && took_m && !slave_resp);
    cov_slave_ack: cover property (pci_internal_ack_pulse_n_done && slave_resp);
    cov_spurious: cover property (pci_internal_ack_pulse_n_done && !took_m);
    cov_nested: cover property (|in_service_bits[MASTER] && cpu_irq_out);

endmodule

// ===== verification/clpp_host_model.sv
// Purpose: Host bridge stand-in that issues acknowledge cycles
// Assumes: A request is made only while the block is idle
// Notes:   Counts internal pulses and snapshots the cascade code after pulse one
`timescale 1ns/1ps
module clpp_host_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       go,
    input  wire logic       pci_internal_ack_pulse_n_done,
    input  wire logic       internal_ack_pulse_n,
    input  wire logic [2:0] cascade_code,
    input  wire logic [7:0] pci_internal_ack_pulse_n_vector,
    output logic            pci_internal_ack_pulse_n_req,
    output logic            busy,
    output logic [1:0]      pulses,
    output logic [2:0]      code_seen,
    output logic [7:0]      vec_seen
);
    logic ack_q;

    always_ff @(posedge sys_clk) begin
        ack_q        <= internal_ack_pulse_n;
        pci_internal_ack_pulse_n_req <= 1'b0;
        if (rst) begin
            busy      <= 1'b0;
            pulses    <= 2'h0;
            code_seen <= 3'h0;
            vec_seen  <= 8'h00;
        end else if (go && !busy) begin
            pci_internal_ack_pulse_n_req <= 1'b1;
            busy         <= 1'b1;
            pulses       <= 2'h0;
        end else if (busy) begin
            // A third pulse makes the count three and a fourth wraps it to zero, so one or two extra pulses never read as two
            if (ack_q && !internal_ack_pulse_n) begin
                pulses <= pulses + 2'h1;
            end
            if (!ack_q && internal_ack_pulse_n && pulses == 2'h1) begin
                code_seen <= cascade_code;
            end
            if (pci_internal_ack_pulse_n_done) begin
                busy     <= 1'b0;
                vec_seen <= pci_internal_ack_pulse_n_vector;
            end
        end
    end
endmodule

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for the cascaded controller pair
// Assumes: Host model drives the acknowledge request
// Notes:   Random levels and vector bases from a fixed-seed shift register
`timescale 1ns/1ps
module tb_top
    import clpp_pkg::*;
;
    logic                            sys_clk = 1'b0;
    logic                            rst = 1'b1;
    clpp_sw_cmd_t                    sw_cmd = '0;
    logic                            auto_end_of_service_mode = 1'b0;
    logic [15:0]                     edge_level_sel = 16'h0000;
    logic                            latch_irq1_en = 1'b0;
    logic                            kbd_latch_clear = 1'b0;
    logic                            multimedia_timer0 = 1'b0;
    logic                            rtc_irq = 1'b0;
    logic                            fpu_error_n = 1'b1;
    logic [15:0]                     serialized_irq_link = 16'h0000;
    logic                            ide_pri_irq = 1'b0;
    logic                            ide_pri_legacy = 1'b0;
    logic                            latch_irq12_en = 1'b0;
    logic                            timer0_out = 1'b0;
    logic                            multimedia_timer1 = 1'b0;
    logic                            ide_sec_irq = 1'b0;
    logic                            ide_sec_legacy = 1'b0;
    logic                            go = 1'b0;
    logic                            cpu_irq_out, internal_ack_pulse_n, pci_internal_ack_pulse_n_done;
    logic                            pci_internal_ack_pulse_n_req, busy;
    logic [2:0]                      cascade_code, code_seen, idx;
    logic [1:0]                      pulses;
    logic [7:0]                      pci_internal_ack_pulse_n_vector, vec_seen;
    logic [4:0]                      base;
    logic [31:0]                     lfsr = 32'hcb88;
    logic                            sl;
    clpp_core_stat_t [NUM_CORES-1:0] core_status;
    int                              err_total = 0;
    int                              n_compared = 0;

    always #50 sys_clk = ~sys_clk;

    clpp_top DUT (.sys_clk(sys_clk), .rst(rst), .sw_cmd(sw_cmd),
        .auto_end_of_service_mode(auto_end_of_service_mode), .edge_level_sel(edge_level_sel),
        .latch_irq12_en(latch_irq12_en), .latch_irq1_en(latch_irq1_en),
        .kbd_latch_clear(kbd_latch_clear), .timer0_out(timer0_out),
        .multimedia_timer0(multimedia_timer0), .rtc_irq(rtc_irq),
        .multimedia_timer1(multimedia_timer1), .fpu_error_n(fpu_error_n),
        .serialized_irq_link(serialized_irq_link), .ide_pri_irq(ide_pri_irq),
        .ide_sec_irq(ide_sec_irq), .ide_pri_legacy(ide_pri_legacy),
        .ide_sec_legacy(ide_sec_legacy),
        .pci_internal_ack_pulse_n_req(pci_internal_ack_pulse_n_req), .cpu_irq_out(cpu_irq_out),
        .internal_ack_pulse_n(internal_ack_pulse_n), .cascade_code(cascade_code),
        .pci_internal_ack_pulse_n_done(pci_internal_ack_pulse_n_done), .pci_internal_ack_pulse_n_vector(pci_internal_ack_pulse_n_vector),
        .core_status(core_status));

    clpp_host_model host (.sys_clk(sys_clk), .rst(rst), .go(go), .pci_internal_ack_pulse_n_done(pci_internal_ack_pulse_n_done),
        .internal_ack_pulse_n(internal_ack_pulse_n), .cascade_code(cascade_code),
        .pci_internal_ack_pulse_n_vector(pci_internal_ack_pulse_n_vector), .pci_internal_ack_pulse_n_req(pci_internal_ack_pulse_n_req), .busy(busy),
        .pulses(pulses), .code_seen(code_seen), .vec_seen(vec_seen));

    function automatic logic [31:0] nextl(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [7:0] vec(input logic [4:0] b, input logic [2:0] i);
        return {b, i};
    endfunction

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic cmd(input logic [1:0] mw, input logic [1:0] bw, input logic [1:0] eo,
                       input logic [7:0] d);
        @(posedge sys_clk) sw_cmd <= {mw, bw, eo, d};
        @(posedge sys_clk) sw_cmd <= '0;
        tick(1);
    endtask

    // Sequence length is bounded, a hang shows as a busy flag left high
    task automatic ack(input logic [7:0] exp_v, input logic chk_c, input logic [2:0] exp_c);
        int k;
        @(posedge sys_clk) go <= 1'b1;
        @(posedge sys_clk) go <= 1'b0;
        tick(1);
        for (k = 0; k < 20 && busy !== 1'b0; k++) tick(1);
        chk("ack finished", busy, 8'h00);
        chk("vector", vec_seen, exp_v);
        chk("pulse count", pulses, 8'h02);
        if (chk_c) chk("cascade code", code_seen, exp_c);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        conclude();
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        tick(1);
        for (int c = 0; c < 2; c++) begin
            chk("irr reset", core_status[c].pending_request_bits, 8'h00);
            chk("isr reset", core_status[c].in_service_bits, 8'h00);
            chk("imr reset", core_status[c].request_mask_bits, 8'hff);
        end
        cmd(2'b00, 2'b01, 2'b00, 8'h40);
        cmd(2'b00, 2'b10, 2'b00, 8'h70);
        @(posedge sys_clk) serialized_irq_link <= 16'h0028;
        tick(4);
        chk("irr while masked", core_status[0].pending_request_bits, 8'h28);
        chk("irq while masked", cpu_irq_out, 8'h00);
        cmd(2'b11, 2'b00, 2'b00, 8'h00);
        tick(1);
        chk("irq unmasked", cpu_irq_out, 8'h01);
        ack(vec(5'h08, 3'h3), 1'b1, 3'h3);
        chk("irr after ack", core_status[0].pending_request_bits, 8'h20);
        chk("isr after ack", core_status[0].in_service_bits, 8'h08);
        tick(2);
        chk("irq below service", cpu_irq_out, 8'h00);
        cmd(2'b00, 2'b00, 2'b01, 8'h00);
        tick(1);
        chk("isr after eoi", core_status[0].in_service_bits, 8'h00);
        chk("irq after eoi", cpu_irq_out, 8'h01);
        ack(vec(5'h08, 3'h5), 1'b1, 3'h5);
        cmd(2'b00, 2'b00, 2'b01, 8'h00);
        @(posedge sys_clk) serialized_irq_link <= 16'h0000;
        tick(3);
        ack(vec(5'h08, 3'h7), 1'b0, 3'h0);
        chk("isr after spurious", core_status[0].in_service_bits, 8'h00);
        @(posedge sys_clk) {ide_pri_legacy, ide_pri_irq} <= 2'b11;
        tick(4);
        ack(vec(5'h0e, 3'h6), 1'b1, 3'h2);
        chk("slave isr", core_status[1].in_service_bits, 8'h40);
        chk("master isr cascade", core_status[0].in_service_bits, 8'h04);
        cmd(2'b00, 2'b00, 2'b11, 8'h00);
        @(posedge sys_clk) {ide_pri_legacy, ide_pri_irq} <= 2'b00;
        @(posedge sys_clk) ide_pri_irq <= 1'b1;
        tick(4);
        chk("drive pin not legacy", core_status[1].pending_request_bits[6], 8'h00);
        @(posedge sys_clk) serialized_irq_link[14] <= 1'b1;
        tick(4);
        chk("level 14 via link", core_status[1].pending_request_bits[6], 8'h01);
        ack(vec(5'h0e, 3'h6), 1'b1, 3'h2);
        cmd(2'b00, 2'b00, 2'b11, 8'h00);
        @(posedge sys_clk) {serialized_irq_link[14], ide_pri_irq} <= 2'b00;
        @(posedge sys_clk) {fpu_error_n, rtc_irq, multimedia_timer0} <= 3'b011;
        tick(4);
        chk("slave internal inputs", core_status[1].pending_request_bits, 8'h21);
        chk("master timer input", core_status[0].pending_request_bits[0], 8'h01);
        ack(vec(5'h08, 3'h0), 1'b1, 3'h0);
        cmd(2'b00, 2'b00, 2'b01, 8'h00);
        ack(vec(5'h0e, 3'h0), 1'b1, 3'h2);
        cmd(2'b00, 2'b00, 2'b11, 8'h00);
        @(posedge sys_clk) auto_end_of_service_mode <= 1'b1;
        ack(vec(5'h0e, 3'h5), 1'b1, 3'h2);
        tick(1);
        chk("auto clear slave", core_status[1].in_service_bits, 8'h00);
        chk("auto clear master", core_status[0].in_service_bits, 8'h00);
        @(posedge sys_clk) {auto_end_of_service_mode, fpu_error_n, rtc_irq} <= 3'b010;
        @(posedge sys_clk) edge_level_sel <= 16'h0013;
        tick(4);
        chk("level 0 stays edge", core_status[0].pending_request_bits[0], 8'h00);
        @(posedge sys_clk) {multimedia_timer0, serialized_irq_link[4]} <= 2'b01;
        tick(4);
        chk("level mode set", core_status[0].pending_request_bits[4], 8'h01);
        @(posedge sys_clk) serialized_irq_link[4] <= 1'b0;
        tick(4);
        chk("level mode drop", core_status[0].pending_request_bits[4], 8'h00);
        @(posedge sys_clk) {latch_irq1_en, serialized_irq_link[1]} <= 2'b11;
        @(posedge sys_clk) serialized_irq_link[1] <= 1'b0;
        tick(4);
        chk("level 1 latched", core_status[0].pending_request_bits[1], 8'h01);
        @(posedge sys_clk) kbd_latch_clear <= 1'b1;
        @(posedge sys_clk) kbd_latch_clear <= 1'b0;
        tick(4);
        chk("latch cleared", core_status[0].pending_request_bits[1], 8'h00);
        @(posedge sys_clk) {latch_irq1_en, latch_irq12_en, serialized_irq_link[12]} <= 3'b011;
        @(posedge sys_clk) {edge_level_sel, serialized_irq_link[12]} <= 17'h02000;
        tick(4);
        chk("level 12 latched", core_status[1].pending_request_bits[4], 8'h01);
        ack(vec(5'h0e, 3'h4), 1'b1, 3'h2);
        cmd(2'b00, 2'b00, 2'b11, 8'h00);
        @(posedge sys_clk) kbd_latch_clear <= 1'b1;
        @(posedge sys_clk) kbd_latch_clear <= 1'b0;
        tick(2);
        chk("level 12 released", core_status[1].pending_request_bits[4], 8'h00);
        @(posedge sys_clk) {latch_irq12_en, edge_level_sel} <= 17'h00000;
        @(posedge sys_clk) {ide_sec_legacy, ide_sec_irq, timer0_out, multimedia_timer1} <= 4'hf;
        tick(4);
        chk("level 15 drive pin", core_status[1].pending_request_bits[7], 8'h01);
        chk("alternate timers", {core_status[1].pending_request_bits[0], core_status[0].pending_request_bits[0]}, 8'h03);
        ack(vec(5'h08, 3'h0), 1'b1, 3'h0);
        cmd(2'b00, 2'b00, 2'b01, 8'h00);
        ack(vec(5'h0e, 3'h0), 1'b1, 3'h2);
        cmd(2'b00, 2'b00, 2'b11, 8'h00);
        ack(vec(5'h0e, 3'h7), 1'b1, 3'h2);
        cmd(2'b00, 2'b00, 2'b11, 8'h00);
        @(posedge sys_clk) {ide_sec_legacy, ide_sec_irq, timer0_out, multimedia_timer1} <= 4'h0;
        for (int i = 0; i < 12; i++) begin
            lfsr = nextl(lfsr);
            sl = lfsr[16];
            idx = (lfsr[2:0] == 3'h0 || lfsr[2:0] == 3'h2) ? 3'h7 : lfsr[2:0];
            if (sl && idx == 3'h5) idx = 3'h3;
            base = lfsr[12:8];
            cmd(2'b00, sl ? 2'b10 : 2'b01, 2'b00, {base, 3'h0});
            @(posedge sys_clk) serialized_irq_link[{sl, idx}] <= 1'b1;
            tick(4);
            ack(vec(base, idx), 1'b1, sl ? 3'h2 : idx);
            @(posedge sys_clk) serialized_irq_link[{sl, idx}] <= 1'b0;
            cmd(2'b00, 2'b00, sl ? 2'b11 : 2'b01, 8'h00);
            chk("isr after eoi", core_status[0].in_service_bits, 8'h00);
        end
        conclude();
    end
endmodule
